// *** hdl/swr_pkg.sv ***
// Constants and carrier types for the expiry reset timer.
// Summary of operation
// - Two successive writes of 87 to index port 2E unlock configuration access.
// - Write 20 to index 2D, 08 to index 07, 01 to index 30 to run.
// - Index F5 picks the time base: 00 seconds, 08 minutes.
// - Index F6 holds the 8-bit count, 0 to 255, in the selected unit.
// - A count of zero never produces a timeout in either unit.
// - Seconds unit: nonzero count n times out n seconds after loading.
// - Minutes unit: nonzero count n times out n minutes after loading.
// - Every write to index F6 while device 08 is selected reloads the counter and restarts the countdown.
// - Expiry without reload asserts the system reset output.
// - Writing 00 to index 30 while device 08 is selected disables the timer, except when the write lands in the cycle of the final tick, which still expires.
package swr_pkg;

  localparam logic [7:0] INDEX_PORT = 8'h2e;
  localparam logic [7:0] DATA_PORT = 8'h2f;
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] LOCK_KEY = 8'haa;

  localparam logic [7:0] IDX_DEVICE_SELECT = 8'h07;
  localparam logic [7:0] IDX_FUNCTION_SETUP = 8'h2d;
  localparam logic [7:0] IDX_ACTIVATION = 8'h30;
  localparam logic [7:0] IDX_UNIT_SELECT = 8'hf5;
  localparam logic [7:0] IDX_COUNTDOWN = 8'hf6;

  localparam logic [7:0] TIMER_DEVICE = 8'h08;
  localparam int ARM_BIT = 5;
  localparam int ACTIVE_BIT = 0;
  localparam int MINUTES_BIT = 3;

  localparam logic [7:0] RST_DEVICE_SELECT = 8'h00;
  localparam logic [7:0] RST_FUNCTION_SETUP = 8'h00;
  localparam logic [7:0] RST_ACTIVATION = 8'h00;
  localparam logic [7:0] RST_UNIT_SELECT = 8'h00;
  localparam logic [7:0] RST_COUNTDOWN = 8'h00;
  localparam logic [7:0] LOCKED_READ = 8'hff;

  localparam int CLOCK_HZ = 40_000_000;
  localparam int TICK_SECONDS = 1;
  localparam int SECOND_CYCLES = CLOCK_HZ * TICK_SECONDS;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int RESET_PULSE_CYCLES = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } swr_io_req_s;

endpackage

// *** hdl/swr_watchdog.sv ***
// Expiry reset timer reached through an index port and a data port.
`timescale 1ns/10ps
`default_nettype none

module swr_watchdog #(
  parameter int SECOND_CYCLES = swr_pkg::SECOND_CYCLES,
  parameter int SECONDS_PER_MINUTE = swr_pkg::SECONDS_PER_MINUTE,
  parameter int RESET_PULSE_CYCLES = swr_pkg::RESET_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire swr_pkg::swr_io_req_s ioReq,
  output logic [7:0] readData,
  output logic readValid,
  output logic systemReset
);

  localparam int PRE_W = $clog2(SECOND_CYCLES + 1);
  localparam int MIN_W = $clog2(SECONDS_PER_MINUTE + 1);
  localparam int PULSE_W = $clog2(RESET_PULSE_CYCLES + 1);

  logic [1:0] keyCount;
  logic unlocked;
  logic [7:0] index;
  logic [7:0] deviceSelect;
  logic [7:0] functionSetup;
  logic [7:0] activation;
  logic [7:0] unitSelect;
  logic [7:0] remaining;
  logic [PRE_W-1:0] prescale;
  logic [MIN_W-1:0] secondCount;
  logic [PULSE_W-1:0] pulseCount;
  logic indexWrite;
  logic cfgWrite;
  logic timerSelected;
  logic countLoad;
  logic running;
  logic secondTick;
  logic minuteTick;
  logic unitTick;
  logic expire;
  logic [7:0] next_readData;

  assign indexWrite = ioReq.wr && ioReq.addr == swr_pkg::INDEX_PORT;
  assign unlocked = keyCount == 2'h2;
  assign cfgWrite = unlocked && ioReq.wr && ioReq.addr == swr_pkg::DATA_PORT;
  assign timerSelected = deviceSelect == swr_pkg::TIMER_DEVICE;
  assign countLoad = cfgWrite && timerSelected && index == swr_pkg::IDX_COUNTDOWN;
  // Both the arm value and the activation bit must be set before anything counts.
  assign running = functionSetup[swr_pkg::ARM_BIT] && activation[swr_pkg::ACTIVE_BIT];
  assign secondTick = running && prescale == PRE_W'(SECOND_CYCLES - 1);
  assign minuteTick = secondTick && secondCount == MIN_W'(SECONDS_PER_MINUTE - 1);
  assign unitTick = unitSelect[swr_pkg::MINUTES_BIT] ? minuteTick : secondTick;
  // A zero count never reaches the one-to-zero step, so it never expires.
  assign expire = !countLoad && unitTick && remaining == 8'h01;

  // A stray index write between the two keys starts the unlock over.
  always_ff @(posedge clk) begin
    if (rst) begin
      keyCount <= 2'h0;
    end else if (indexWrite) begin
      if (unlocked) begin
        if (ioReq.data == swr_pkg::LOCK_KEY) begin
          keyCount <= 2'h0;
        end
      end else if (ioReq.data == swr_pkg::UNLOCK_KEY) begin
        keyCount <= keyCount + 2'h1;
      end else begin
        keyCount <= 2'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      index <= 8'h00;
    end else if (indexWrite && unlocked && ioReq.data != swr_pkg::LOCK_KEY) begin
      index <= ioReq.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      deviceSelect <= swr_pkg::RST_DEVICE_SELECT;
      functionSetup <= swr_pkg::RST_FUNCTION_SETUP;
    end else if (cfgWrite) begin
      if (index == swr_pkg::IDX_DEVICE_SELECT) begin
        deviceSelect <= ioReq.data;
      end
      if (index == swr_pkg::IDX_FUNCTION_SETUP) begin
        functionSetup <= ioReq.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      activation <= swr_pkg::RST_ACTIVATION;
      unitSelect <= swr_pkg::RST_UNIT_SELECT;
    end else if (cfgWrite && timerSelected) begin
      if (index == swr_pkg::IDX_ACTIVATION) begin
        activation <= ioReq.data;
      end
      if (index == swr_pkg::IDX_UNIT_SELECT) begin
        unitSelect <= ioReq.data;
      end
    end
  end

  // The tick restarts on reload so the first step is a full unit after the write.
  always_ff @(posedge clk) begin
    if (rst || countLoad || !running) begin
      prescale <= '0;
    end else if (secondTick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PRE_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || countLoad || !running) begin
      secondCount <= '0;
    end else if (minuteTick) begin
      secondCount <= '0;
    end else if (secondTick) begin
      secondCount <= secondCount + MIN_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      remaining <= swr_pkg::RST_COUNTDOWN;
    end else if (countLoad) begin
      remaining <= ioReq.data;
    end else if (unitTick && remaining != 8'h00) begin
      remaining <= remaining - 8'h01;
    end
  end

  // The reset is a fixed-length pulse so the far side sees a clean edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      pulseCount <= '0;
      systemReset <= 1'b0;
    end else if (expire) begin
      pulseCount <= PULSE_W'(RESET_PULSE_CYCLES - 1);
      systemReset <= 1'b1;
    end else if (pulseCount != '0) begin
      pulseCount <= pulseCount - PULSE_W'(1);
    end else begin
      systemReset <= 1'b0;
    end
  end

  always_comb begin
    next_readData = swr_pkg::LOCKED_READ;
    if (unlocked && ioReq.addr == swr_pkg::INDEX_PORT) begin
      next_readData = index;
    end else if (unlocked && ioReq.addr == swr_pkg::DATA_PORT) begin
      next_readData = 8'h00;
      if (index == swr_pkg::IDX_DEVICE_SELECT) begin
        next_readData = deviceSelect;
      end else if (index == swr_pkg::IDX_FUNCTION_SETUP) begin
        next_readData = functionSetup;
      end else if (timerSelected && index == swr_pkg::IDX_ACTIVATION) begin
        next_readData = activation;
      end else if (timerSelected && index == swr_pkg::IDX_UNIT_SELECT) begin
        next_readData = unitSelect;
      end else if (timerSelected && index == swr_pkg::IDX_COUNTDOWN) begin
        next_readData = remaining;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readData <= 8'h00;
      readValid <= 1'b0;
    end else begin
      readValid <= ioReq.rd;
      if (ioReq.rd) begin
        readData <= next_readData;
      end
    end
  end

endmodule

`default_nettype wire

// *** verif/swr_watchdog_chk.sv ***
// Port assertions for the expiry reset timer.
`timescale 1ns/10ps
`default_nettype none
module swr_watchdog_chk (
  input wire logic clk,
  input wire logic rst,
  input wire swr_pkg::swr_io_req_s ioReq,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire logic systemReset
);
  logic [7:0] idx;
  logic [1:0] keys;
  logic sel;
  wire logic iw = ioReq.wr && ioReq.addr == 8'h2e;
  wire logic dw = ioReq.wr && ioReq.addr == 8'h2f && keys[1];
  wire logic load = dw && sel && idx == 8'hf6;
  // Shadow of the unlock and select state, so that ignored writes raise no claims.
  always_ff @(posedge clk) begin
    if (rst) begin
      idx <= 8'h00;
      keys <= 2'h0;
      sel <= 1'b0;
    end else begin
      if (iw) begin
        idx <= ioReq.data;
        keys <= (ioReq.data == 8'haa) ? 2'h0 : keys[1] ? 2'h2 : (ioReq.data == 8'h87) ? keys + 2'h1 : 2'h0;
      end
      if (dw && idx == 8'h07) begin
        sel <= ioReq.data == 8'h08;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    (!$rose(systemReset)) [*8];
  endsequence
  a_read_answer: assert property (ioReq.rd |=> readValid) else $error("read not answered");
  a_valid_only_read: assert property (!ioReq.rd |=> !readValid) else $error("stray read valid");
  a_locked_read: assert property (ioReq.rd && ioReq.addr == 8'h2f && !keys[1] |=> readData == 8'hff)
    else $error("locked read value wrong");
  a_pulse_length: assert property ($rose(systemReset) |=> systemReset [*8]) else $error("reset pulse short");
  a_reload_quiet: assert property (load && ioReq.data != 8'h00 |=> s_quiet) else $error("reset after reload");
  a_zero_quiet: assert property (load && ioReq.data == 8'h00 |=> s_quiet) else $error("zero count expired");
  a_disable_quiet: assert property (dw && sel && idx == 8'h30 && ioReq.data == 8'h00 |=> s_quiet)
    else $error("reset after disable");
  a_reset_idle: assert property ($fell(rst) |-> !systemReset && !readValid) else $error("outputs busy at reset");
endmodule
bind swr_watchdog swr_watchdog_chk u_chk (.clk(clk), .rst(rst), .ioReq(ioReq), .readData(readData),
  .readValid(readValid), .systemReset(systemReset));
`default_nettype wire

// *** verif/swr_host.sv ***
// Host model driving the index and data ports.
`timescale 1ns/10ps
`default_nettype none
module swr_host (
  input wire logic clk,
  input wire logic [7:0] readData,
  output var swr_pkg::swr_io_req_s ioReq
);
  initial ioReq = '0;
  // Each access is one strobe cycle followed by an idle cycle, so no signal is driven twice in a step.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ioReq <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    ioReq <= '0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    put(8'h2e, i);
    put(8'h2f, d);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    put(8'h2e, i);
    @(posedge clk);
    ioReq <= {1'b0, 1'b1, 8'h2f, 8'h00};
    @(posedge clk);
    ioReq <= '0;
    #1 d = readData;
  endtask
  task automatic unlock;
    put(8'h2e, 8'h87);
    put(8'h2e, 8'h87);
  endtask
  task automatic setup;
    wr(8'h2d, 8'h20);
    wr(8'h07, 8'h08);
    wr(8'h30, 8'h01);
  endtask
endmodule
`default_nettype wire

// *** verif/swr_watchdog_tb_top.sv ***
// Self-checking bench for the expiry reset timer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t mismatch", $time); end end
module swr_watchdog_tb_top;
  localparam int SEC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int err_count = 0;
  int n_compared = 0;
  int pulses = 0;
  int p;
  logic [7:0] v;
  swr_pkg::swr_io_req_s ioReq;
  logic [7:0] readData;
  logic readValid;
  logic systemReset;
  always #12.5 clk = ~clk;
  always @(posedge systemReset) pulses++;
  swr_host host (.clk(clk), .readData(readData), .ioReq(ioReq));
  swr_watchdog #(.SECOND_CYCLES(SEC), .SECONDS_PER_MINUTE(3), .RESET_PULSE_CYCLES(16)) dut (.clk(clk),
    .rst(rst), .ioReq(ioReq), .readData(readData), .readValid(readValid), .systemReset(systemReset));
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Load a count and measure the cycles until the reset request rises.
  task automatic expire(input logic [7:0] n, input int exp);
    int c;
    c = 0;
    host.wr(8'hf6, n);
    #1;
    while (systemReset !== 1'b1 && c < exp + 40) begin
      @(posedge clk);
      #1;
      c++;
    end
    `CHK(c >= exp - 1 && c <= exp + 2, 1'b1)
    repeat (20) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    host.rd(8'h30, v);
    `CHK(v, 8'hff)
    host.unlock();
    host.setup();
    host.rd(8'h30, v);
    `CHK(readValid, 1'b1)
    `CHK(v, 8'h01)
    host.wr(8'hf5, 8'h00);
    expire(8'h01, SEC);
    expire(8'hff, 255 * SEC);
    host.wr(8'hf6, 8'h03);
    repeat (20) @(posedge clk);
    expire(8'h03, 3 * SEC);
    p = pulses;
    host.wr(8'hf6, 8'h00);
    repeat (60) @(posedge clk);
    `CHK(pulses, p)
    host.wr(8'hf5, 8'h08);
    host.rd(8'hf5, v);
    `CHK(v, 8'h08)
    expire(8'h02, 2 * 3 * SEC);
    host.wr(8'hf6, 8'hff);
    host.rd(8'hf6, v);
    `CHK(v, 8'hff)
    host.wr(8'hf5, 8'h00);
    host.wr(8'hf6, 8'h02);
    repeat (5) @(posedge clk);
    p = pulses;
    host.wr(8'h30, 8'h00);
    repeat (60) @(posedge clk);
    `CHK(pulses, p)
    wrap_up();
  end
  // The tests need about 3000 cycles; a hang is cut well beyond that.
  initial begin
    #(25 * 20000);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
